// [hw/hour_meter_pkg.sv]
/*
  constants shared by the on-time meter and its word store: field widths,
  limits, index ranges, reset values and the one-second tick count.
  assumes a 20 MHz core clock.
*/
`default_nettype none
package hour_meter_pkg;
  // field widths
  localparam int HOURS_W = 16;
  localparam int MINSEC_W = 6;
  localparam int WORD_W = 16;
  // limits of the minute and second fields
  localparam logic [5:0] MINSEC_MAX = 6'h3B;
  localparam logic [15:0] WORD_MINSEC_MAX = 16'h003B;
  // storage words: two windows of start indexes, three words each
  localparam int STORE_DEPTH = 2000;
  localparam int STORE_AW = 11;
  localparam logic [10:0] STORE_LO_LAST = 11'h3E5;  // 997
  localparam logic [10:0] STORE_HI_FIRST = 11'h3E8; // 1000
  localparam logic [10:0] STORE_HI_LAST = 11'h7CD;  // 1997
  // counter words: 200 words, start index 0 to 197
  localparam int COUNT_DEPTH = 200;
  localparam int COUNT_AW = 8;
  localparam logic [7:0] COUNT_LAST = 8'hC5;        // 197
  // word offsets of the three preset fields from the start index
  localparam logic [1:0] OFS_HOURS = 2'h0;
  localparam logic [1:0] OFS_MINUTES = 2'h1;
  localparam logic [1:0] OFS_SECONDS = 2'h2;
  // reset values
  localparam logic [15:0] HOURS_RST = 16'h0000;
  localparam logic [5:0] MINSEC_RST = 6'h00;
  // drop behaviour encodings
  localparam logic DROP_KEEP = 1'b0;
  localparam logic DROP_CLEAR = 1'b1;
  // one-second tick
  localparam longint CLK_PERIOD_NS = 50;
  localparam longint TICK_TIME_NS = 1000000000;
  localparam int TICK_CYCLES = int'(TICK_TIME_NS / CLK_PERIOD_NS);
  // preset fetch sequence
  typedef enum logic [1:0] {FETCH_H, FETCH_M, FETCH_S, FETCH_DONE} fetch_t;
endpackage
`default_nettype wire

// [hw/word_store.sv]
/*
  small single-port-write, single-port-read word memory with a registered
  read data output (one cycle latency).
  assumes one clock; contents are undefined until written.
*/
`timescale 1ns/1ps
`default_nettype none
module word_store #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 200,
  parameter int AW = 8
) (
  // clock
  input wire logic clk,
  // write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // write and registered read; out of range writes are ignored, out of range reads return zero
  always_ff @(posedge clk) begin
    if (wr_en && (int'(wr_addr) < DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
    if (int'(rd_addr) < DEPTH) begin
      rd_data <= mem[rd_addr];
    end else begin
      rd_data <= '0;
    end
  end
endmodule // word_store
`default_nettype wire

// [hw/hour_meter.sv]
/*
  on-time meter: counts hours, minutes and seconds while run is on and the
  meter reset is off, compares against a three word preset and drives the
  comparison output. the preset comes either from counter words (loaded from
  a constant) or from storage words written by the control program.
  assumes all control inputs are synchronous to clk.
*/
// Function
// - count time only while run is on and meter reset is off
// - meter reset zeroes time and drives the output low
// - meter reset beats run; nothing counts during reset
// - tie meter reset low when unused; it is then never asserted
// - output high when time is at or above preset, hours first
// - keep mode holds a high output after run drops until reset
// - clear mode drops the output as soon as run drops
// - time is retained while run is off and resumes from there
// - constant preset sits in three counter words hours, minutes, seconds
// - storage preset read from three words at index 0-997 or 1000-1997
// - past 65535:59:59 hours wrap by 65536 and counting goes on
// - bad preset field flags an error and forces output low
`timescale 1ns/1ps
`default_nettype none
module hour_meter #(
  parameter int TICK_CYCLES = hour_meter_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // meter control
  input wire logic run,
  input wire logic meter_reset,
  input wire logic drop_behaviour_select,
  // preset source: 0 counter words, 1 storage words
  input wire logic preset_from_store,
  input wire logic [7:0] counter_index,
  input wire logic [10:0] store_index,
  // constant preset load into counter words
  input wire logic const_load,
  input wire logic [15:0] const_hours,
  input wire logic [15:0] const_minutes,
  input wire logic [15:0] const_seconds,
  // storage word write port
  input wire logic store_wr_en,
  input wire logic [10:0] store_wr_addr,
  input wire logic [15:0] store_wr_data,
  // results
  output logic meter_out,
  output logic exec_error,
  output logic [15:0] acc_hours,
  output logic [5:0] acc_minutes,
  output logic [5:0] acc_seconds,
  output logic [15:0] preset_hours,
  output logic [15:0] preset_minutes,
  output logic [15:0] preset_seconds
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  // valid start index in the storage windows
  function automatic logic store_index_ok(input logic [10:0] idx);
    return (idx <= hour_meter_pkg::STORE_LO_LAST) ||
           ((idx >= hour_meter_pkg::STORE_HI_FIRST) &&
            (idx <= hour_meter_pkg::STORE_HI_LAST));
  endfunction

  // accumulated time at or above the preset, hours then minutes then seconds
  function automatic logic time_ge(
    input logic [15:0] ah, input logic [5:0] am, input logic [5:0] as_,
    input logic [15:0] ph, input logic [15:0] pm, input logic [15:0] ps);
    if (ah != ph) begin
      return ah > ph;
    end
    if ({10'h000, am} != pm) begin
      return {10'h000, am} > pm;
    end
    return {10'h000, as_} >= ps;
  endfunction

  logic [TW-1:0] prescale, next_prescale;
  logic [15:0] next_acc_hours;
  logic [5:0] next_acc_minutes, next_acc_seconds;
  logic next_meter_out, next_exec_error;
  logic tick;
  logic counting;
  hour_meter_pkg::fetch_t fetch, next_fetch;
  logic [1:0] fetch_ofs;
  logic [15:0] fetch_h, next_fetch_h, fetch_m, next_fetch_m;
  logic [15:0] next_preset_hours, next_preset_minutes, next_preset_seconds;
  logic fetch_idx_bad, next_fetch_idx_bad, idx_bad;
  logic [1:0] load_step, next_load_step;
  logic cnt_wr_en;
  logic [7:0] cnt_wr_addr, cnt_rd_addr;
  logic [15:0] cnt_wr_data, cnt_rd_data, store_rd_data, rd_word;
  logic [10:0] store_rd_addr;
  logic preset_bad;

  // counting is gated by run with meter reset on top
  assign counting = run && !meter_reset;
  assign tick = counting && (int'(prescale) == TICK_CYCLES - 1);

  // constant preset written into three counter words, one per cycle
  always_comb begin
    next_load_step = load_step;
    cnt_wr_en = 1'b0;
    cnt_wr_addr = counter_index;
    cnt_wr_data = const_hours;
    if (load_step != 2'h0) begin
      cnt_wr_en = 1'b1;
      unique case (load_step)
        2'h1: begin
          cnt_wr_addr = counter_index + {6'h00, hour_meter_pkg::OFS_HOURS};
          cnt_wr_data = const_hours;
        end
        2'h2: begin
          cnt_wr_addr = counter_index + {6'h00, hour_meter_pkg::OFS_MINUTES};
          cnt_wr_data = const_minutes;
        end
        default: begin
          cnt_wr_addr = counter_index + {6'h00, hour_meter_pkg::OFS_SECONDS};
          cnt_wr_data = const_seconds;
        end
      endcase
      next_load_step = (load_step == 2'h3) ? 2'h0 : load_step + 2'h1;
    end else if (const_load) begin
      next_load_step = 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_step <= 2'h0;
    end else begin
      load_step <= next_load_step;
    end
  end

  // preset fetch: address one word per state, data returns a cycle later
  always_comb begin
    unique case (fetch)
      hour_meter_pkg::FETCH_H: fetch_ofs = hour_meter_pkg::OFS_HOURS;
      hour_meter_pkg::FETCH_M: fetch_ofs = hour_meter_pkg::OFS_MINUTES;
      hour_meter_pkg::FETCH_S: fetch_ofs = hour_meter_pkg::OFS_SECONDS;
      hour_meter_pkg::FETCH_DONE: fetch_ofs = hour_meter_pkg::OFS_HOURS;
    endcase
  end

  assign cnt_rd_addr = counter_index + {6'h00, fetch_ofs};
  assign store_rd_addr = store_index + {9'h000, fetch_ofs};
  assign rd_word = preset_from_store ? store_rd_data : cnt_rd_data;
  assign idx_bad = preset_from_store ?
                   !store_index_ok(store_index) :
                   (counter_index > hour_meter_pkg::COUNT_LAST);

  always_comb begin
    next_fetch = fetch;
    next_fetch_h = fetch_h;
    next_fetch_m = fetch_m;
    next_fetch_idx_bad = fetch_idx_bad;
    next_preset_hours = preset_hours;
    next_preset_minutes = preset_minutes;
    next_preset_seconds = preset_seconds;
    unique case (fetch)
      hour_meter_pkg::FETCH_H: begin
        next_fetch_idx_bad = idx_bad;
        next_fetch = hour_meter_pkg::FETCH_M;
      end
      hour_meter_pkg::FETCH_M: begin
        next_fetch_h = rd_word;
        next_fetch = hour_meter_pkg::FETCH_S;
      end
      hour_meter_pkg::FETCH_S: begin
        next_fetch_m = rd_word;
        next_fetch = hour_meter_pkg::FETCH_DONE;
      end
      hour_meter_pkg::FETCH_DONE: begin
        // the three fields change together
        next_preset_hours = fetch_h;
        next_preset_minutes = fetch_m;
        next_preset_seconds = rd_word;
        next_fetch = hour_meter_pkg::FETCH_H;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch <= hour_meter_pkg::FETCH_H;
      fetch_h <= 16'h0000;
      fetch_m <= 16'h0000;
      fetch_idx_bad <= 1'b0;
      preset_hours <= 16'h0000;
      preset_minutes <= 16'h0000;
      preset_seconds <= 16'h0000;
    end else begin
      fetch <= next_fetch;
      fetch_h <= next_fetch_h;
      fetch_m <= next_fetch_m;
      fetch_idx_bad <= next_fetch_idx_bad;
      preset_hours <= next_preset_hours;
      preset_minutes <= next_preset_minutes;
      preset_seconds <= next_preset_seconds;
    end
  end

  // range check of the preset minutes and seconds fields and of the start index
  assign preset_bad = (preset_minutes > hour_meter_pkg::WORD_MINSEC_MAX) ||
                      (preset_seconds > hour_meter_pkg::WORD_MINSEC_MAX) ||
                      fetch_idx_bad;

  // time accumulation, output and error
  always_comb begin
    next_prescale = prescale;
    next_acc_hours = acc_hours;
    next_acc_minutes = acc_minutes;
    next_acc_seconds = acc_seconds;
    if (meter_reset) begin
      next_prescale = '0;
      next_acc_hours = hour_meter_pkg::HOURS_RST;
      next_acc_minutes = hour_meter_pkg::MINSEC_RST;
      next_acc_seconds = hour_meter_pkg::MINSEC_RST;
    end else if (counting) begin
      next_prescale = tick ? '0 : prescale + TW'(1);
      if (tick) begin
        if (acc_seconds == hour_meter_pkg::MINSEC_MAX) begin
          next_acc_seconds = hour_meter_pkg::MINSEC_RST;
          if (acc_minutes == hour_meter_pkg::MINSEC_MAX) begin
            next_acc_minutes = hour_meter_pkg::MINSEC_RST;
            next_acc_hours = acc_hours + 16'h0001;
          end else begin
            next_acc_minutes = acc_minutes + 6'h01;
          end
        end else begin
          next_acc_seconds = acc_seconds + 6'h01;
        end
      end
    end
    // run off with reset off: time and prescaler held as they are
    next_exec_error = preset_bad;
    if (meter_reset) begin
      next_meter_out = 1'b0;
    end else if (preset_bad) begin
      next_meter_out = 1'b0;
    end else if (run) begin
      next_meter_out = time_ge(acc_hours, acc_minutes, acc_seconds,
        preset_hours, preset_minutes, preset_seconds);
    end else if (drop_behaviour_select == hour_meter_pkg::DROP_CLEAR) begin
      next_meter_out = 1'b0;
    end else begin
      next_meter_out = meter_out;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= '0;
      acc_hours <= hour_meter_pkg::HOURS_RST;
      acc_minutes <= hour_meter_pkg::MINSEC_RST;
      acc_seconds <= hour_meter_pkg::MINSEC_RST;
      meter_out <= 1'b0;
      exec_error <= 1'b0;
    end else begin
      prescale <= next_prescale;
      acc_hours <= next_acc_hours;
      acc_minutes <= next_acc_minutes;
      acc_seconds <= next_acc_seconds;
      meter_out <= next_meter_out;
      exec_error <= next_exec_error;
    end
  end

  // counter words holding the constant preset
  word_store #(
    .WIDTH(hour_meter_pkg::WORD_W),
    .DEPTH(hour_meter_pkg::COUNT_DEPTH),
    .AW(hour_meter_pkg::COUNT_AW)
  ) count_words (
    .clk(clk),
    .wr_en(cnt_wr_en),
    .wr_addr(cnt_wr_addr),
    .wr_data(cnt_wr_data),
    .rd_addr(cnt_rd_addr),
    .rd_data(cnt_rd_data)
  );

  // storage words written by the control program
  word_store #(
    .WIDTH(hour_meter_pkg::WORD_W),
    .DEPTH(hour_meter_pkg::STORE_DEPTH),
    .AW(hour_meter_pkg::STORE_AW)
  ) store_words (
    .clk(clk),
    .wr_en(store_wr_en),
    .wr_addr(store_wr_addr),
    .wr_data(store_wr_data),
    .rd_addr(store_rd_addr),
    .rd_data(store_rd_data)
  );
endmodule // hour_meter
`default_nettype wire

// [bench/hour_meter_sva.sv]
/*
  checker for the on-time meter, watching the top module ports only.
  assumes one clock domain and an asynchronous active-low rst_n.
*/
`timescale 1ns/1ps
`default_nettype none
module hour_meter_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // meter control
  input wire logic run,
  input wire logic meter_reset,
  input wire logic drop_behaviour_select,
  // results
  input wire logic meter_out,
  input wire logic exec_error,
  input wire logic [15:0] acc_hours,
  input wire logic [5:0] acc_minutes,
  input wire logic [5:0] acc_seconds,
  input wire logic [15:0] preset_hours,
  input wire logic [15:0] preset_minutes,
  input wire logic [15:0] preset_seconds
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a counting cycle with a healthy preset
  sequence s_count;
    run && !meter_reset && !exec_error;
  endsequence
  // one idle cycle in a given drop mode
  sequence s_idle(bit mode);
    drop_behaviour_select == mode && !run && !meter_reset;
  endsequence
  a_reset_zero_time: assert property (meter_reset |=>
    acc_hours == 16'h0000 && acc_minutes == 6'h00 && acc_seconds == 6'h00)
    else $error("time not cleared by meter reset");
  a_reset_out_low: assert property (meter_reset |=> !meter_out)
    else $error("output high after meter reset");
  a_idle_hold_time: assert property (!run && !meter_reset |=>
    $stable({acc_hours, acc_minutes, acc_seconds}))
    else $error("time moved while idle");
  a_field_in_range: assert property (acc_minutes <= 6'h3B &&
    acc_seconds <= 6'h3B) else $error("time field above 59");
  a_second_step: assert property ($changed(acc_seconds) &&
    !$past(meter_reset) |-> acc_seconds == $past(acc_seconds) + 6'h01 ||
    (acc_seconds == 6'h00 && $past(acc_seconds) == 6'h3B))
    else $error("seconds did not step by one");
  a_minute_carry: assert property ($changed(acc_minutes) &&
    !$past(meter_reset) |-> $past(acc_seconds) == 6'h3B &&
    acc_seconds == 6'h00) else $error("minutes moved without carry");
  a_compare_out: assert property (s_count ##1 s_count ##1 !exec_error
    |-> meter_out == ({$past(acc_hours), 10'h000, $past(acc_minutes), 10'h000,
    $past(acc_seconds)} >= {$past(preset_hours), $past(preset_minutes),
    $past(preset_seconds)})) else $error("output disagrees with compare");
  a_error_out_low: assert property (exec_error && $past(exec_error)
    |-> !meter_out) else $error("output high during error");
  a_clear_drop: assert property (s_idle(1'b1) |=> !meter_out)
    else $error("clear mode kept output");
  a_keep_hold: assert property ((s_idle(1'b0) and meter_out)
    ##1 !exec_error |-> meter_out) else $error("keep mode lost output");
endmodule // hour_meter_sva
`default_nettype wire

// [bench/preset_writer.sv]
/*
  control program model: writes a three word preset into storage words.
  assumes requests come a clock after busy has dropped.
*/
`timescale 1ns/1ps
`default_nettype none
module preset_writer (
  // clock and request
  input wire logic clk,
  input wire logic req,
  input wire logic [10:0] base,
  input wire logic [15:0] hrs,
  input wire logic [15:0] mins,
  input wire logic [15:0] secs,
  // storage write port
  output logic wr_en,
  output logic [10:0] wr_addr,
  output logic [15:0] wr_data,
  output logic busy
);
  initial begin
    wr_en = 1'b0;
    wr_addr = 11'h000;
    wr_data = 16'h0000;
    busy = 1'b0;
  end
  // hours, minutes, seconds at base +0, +1, +2; fields written as given, not range checked
  always begin
    @(posedge clk iff req);
    #1 busy = 1'b1;
    wr_en = 1'b1;
    wr_addr = base;
    wr_data = hrs;
    @(posedge clk);
    #1 wr_addr = base + 11'h001;
    wr_data = mins;
    @(posedge clk);
    #1 wr_addr = base + 11'h002;
    wr_data = secs;
    @(posedge clk);
    #1 wr_en = 1'b0;
    busy = 1'b0;
    wr_data = ~wr_data; // a released bus keeps no stale value
  end
endmodule // preset_writer
`default_nettype wire

// [bench/hour_meter_tb_top.sv]
/*
  self-checking bench for the on-time meter with a short tick.
  assumes the checker and the preset writer are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module hour_meter_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, meter_reset = 1'b0;
  logic drop_behaviour_select = 1'b0, preset_from_store = 1'b1;
  logic const_load = 1'b0, req = 1'b0;
  logic [7:0] counter_index = 8'h00;
  logic [10:0] store_index = 11'h3E8;
  logic [15:0] ph = 16'h0000, pm = 16'h0000, ps = 16'h0000;
  logic we, busy, meter_out, exec_error;
  logic [10:0] wa;
  logic [15:0] wd, acc_hours, preset_hours, preset_minutes, preset_seconds;
  logic [5:0] acc_minutes, acc_seconds, old;
  int errors = 0, tests_run = 0;
  always #25 clk = ~clk;
  hour_meter #(.TICK_CYCLES(4)) dut (.clk(clk), .rst_n(rst_n), .run(run),
    .meter_reset(meter_reset), .drop_behaviour_select(drop_behaviour_select),
    .preset_from_store(preset_from_store), .counter_index(counter_index),
    .store_index(store_index), .const_load(const_load),
    .const_hours(16'h0000), .const_minutes(16'h0000),
    .const_seconds(16'h0003), .store_wr_en(we), .store_wr_addr(wa),
    .store_wr_data(wd), .meter_out(meter_out), .exec_error(exec_error),
    .acc_hours(acc_hours), .acc_minutes(acc_minutes),
    .acc_seconds(acc_seconds), .preset_hours(preset_hours),
    .preset_minutes(preset_minutes), .preset_seconds(preset_seconds));
  preset_writer ctl (.clk(clk), .req(req), .base(store_index), .hrs(ph),
    .mins(pm), .secs(ps), .wr_en(we), .wr_addr(wa), .wr_data(wd),
    .busy(busy));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_out(input logic v);
    for (int k = 0; k < 2000 && meter_out !== v; k++) cyc(1);
    chk(meter_out, v);
  endtask
  task automatic load(input logic [15:0] h, m, s);
    ph = h;
    pm = m;
    ps = s;
    req = 1'b1;
    cyc(1);
    req = 1'b0;
    cyc(1);
    for (int k = 0; k < 20 && busy !== 1'b0; k++) cyc(1);
    cyc(10);
  endtask
  task automatic clear_meter();
    meter_reset = 1'b1;
    run = 1'b1; // reset must win over run
    cyc(3);
    chk({acc_hours, acc_minutes, acc_seconds, meter_out}, 48'h0);
    meter_reset = 1'b0;
    run = 1'b0;
  endtask
  // count to the preset, keep the output, then resume
  task automatic t_keep();
    load(16'h0000, 16'h0001, 16'h0002);
    run = 1'b1;
    wait_out(1'b1);
    chk({acc_hours, 10'h0, acc_minutes, 10'h0, acc_seconds}, 48'h10002);
    run = 1'b0;
    old = acc_seconds;
    cyc(30);
    chk(meter_out, 1'b1);
    chk(acc_seconds, old);
    run = 1'b1;
    cyc(30);
    chk(acc_seconds > old, 1'b1);
    clear_meter();
  endtask
  // clear mode drops the output with run
  task automatic t_clear();
    drop_behaviour_select = 1'b1;
    run = 1'b1;
    wait_out(1'b1);
    run = 1'b0;
    cyc(2);
    chk(meter_out, 1'b0);
    drop_behaviour_select = 1'b0;
    clear_meter();
  endtask
  // bad field and bad start index both refuse the compare
  task automatic t_error();
    run = 1'b1;
    load(16'h0000, 16'h0000, 16'h003C);
    old = acc_seconds;
    chk({exec_error, meter_out}, 2'b10);
    cyc(30);
    chk(acc_seconds == old, 1'b0);
    load(16'h0000, 16'h0000, 16'h0005);
    chk(exec_error, 1'b0);
    store_index = 11'h3E6;
    cyc(12);
    chk({exec_error, meter_out}, 2'b10);
    store_index = 11'h3E8;
    clear_meter();
  endtask
  // constant preset in the last legal counter words
  task automatic t_counter();
    preset_from_store = 1'b0;
    counter_index = 8'hC5;
    const_load = 1'b1;
    cyc(1);
    const_load = 1'b0;
    cyc(14);
    chk({preset_hours, preset_minutes, preset_seconds}, 48'h3);
    run = 1'b1;
    wait_out(1'b1);
    chk(acc_seconds, 6'h03);
    clear_meter();
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial begin
    cyc(2);
    rst_n = 1'b1;
    cyc(1);
    chk({acc_hours, acc_minutes, acc_seconds, meter_out}, 48'h0);
    t_keep();
    t_clear();
    t_error();
    t_counter();
    tally_and_finish();
  end
  // watchdog
  initial begin
    #2000000;
    errors++;
    tally_and_finish();
  end
endmodule // hour_meter_tb_top
bind hour_meter hour_meter_sva sva_i (.clk(clk), .rst_n(rst_n), .run(run),
  .meter_reset(meter_reset), .drop_behaviour_select(drop_behaviour_select),
  .meter_out(meter_out), .exec_error(exec_error), .acc_hours(acc_hours),
  .acc_minutes(acc_minutes), .acc_seconds(acc_seconds),
  .preset_hours(preset_hours), .preset_minutes(preset_minutes),
  .preset_seconds(preset_seconds));
`default_nettype wire
